/* logic/sap_engine.sv */
/*
 * Connectionless ARP / echo request engine with its byte register file.
 * Assumes replies arrive as one-cycle pulses from the receive path and
 * that the transmit path takes tx_valid as a one-cycle request.
 */
`timescale 1ns/100ps
`default_nettype none
module sap_engine #(
    parameter int TICK_CYCLES = sap_pkg::TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        rx_arp_reply,
    input  wire logic [47:0] rx_sender_mac,
    input  wire logic        rx_echo_reply,
    input  wire logic        int_pend_zero,
    output logic             tx_valid,
    output logic             tx_is_arp,
    output logic      [31:0] tx_target_ip,
    output logic      [15:0] tx_echo_id,
    output logic      [15:0] tx_echo_seq,
    output logic             interrupt_out_low
);
    sap_pkg::sap_state_e state_reg, state_next;
    logic [1:0]  cmd_reg,   cmd_next;
    logic [15:0] rtr_reg,   rtr_next;
    logic [7:0]  rcr_reg,   rcr_next;
    logic [31:0] pip_reg,   pip_next;
    logic [47:0] mac_reg,   mac_next;
    logic [15:0] seq_reg,   seq_next;
    logic [15:0] id_reg,    id_next;
    logic [2:0]  mask_reg,  mask_next;
    logic [2:0]  flag_reg,  flag_next;
    logic [7:0]  retry_reg, retry_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        txv_reg,   txv_next;
    logic        arp_reg,   arp_next;
    logic        irq_n_reg, irq_n_next;
    logic [2:0]  ev_set;

    sap_timer_if tmr ();

    sap_retry_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tmr     (tmr)
    );

    assign tmr.start    = (state_reg == sap_pkg::ST_SEND);
    assign tmr.stop     = (state_reg == sap_pkg::ST_IDLE);
    assign tmr.interval = rtr_reg;

    // Big-endian byte n of a multi-byte field
    function automatic logic [7:0] pick(input logic [47:0] v,
                                        input int          nbytes,
                                        input logic [15:0] off);
        pick = v[8 * (nbytes - 1 - int'(off)) +: 8];
    endfunction

    function automatic logic [7:0] read_byte(input logic [15:0] a);
        read_byte = 8'h00;
        if (a == sap_pkg::ADDR_CMD)
            read_byte = {6'h00, cmd_reg};
        else if (a >= sap_pkg::ADDR_RTR && a < sap_pkg::ADDR_RCR)
            read_byte = pick({32'h0, rtr_reg}, 2, a - sap_pkg::ADDR_RTR);
        else if (a == sap_pkg::ADDR_RCR)
            read_byte = rcr_reg;
        else if (a >= sap_pkg::ADDR_PIP && a < sap_pkg::ADDR_MAC)
            read_byte = pick({16'h0, pip_reg}, 4, a - sap_pkg::ADDR_PIP);
        else if (a >= sap_pkg::ADDR_MAC && a < sap_pkg::ADDR_SEQ)
            read_byte = pick(mac_reg, 6, a - sap_pkg::ADDR_MAC);
        else if (a >= sap_pkg::ADDR_SEQ && a < sap_pkg::ADDR_ID)
            read_byte = pick({32'h0, seq_reg}, 2, a - sap_pkg::ADDR_SEQ);
        else if (a >= sap_pkg::ADDR_ID && a < sap_pkg::ADDR_MASK)
            read_byte = pick({32'h0, id_reg}, 2, a - sap_pkg::ADDR_ID);
        else if (a == sap_pkg::ADDR_MASK)
            read_byte = {5'h00, mask_reg};
        else if (a == sap_pkg::ADDR_FLAGS)
            read_byte = {5'h00, flag_reg};
    endfunction

    always_comb begin
        state_next = state_reg;
        cmd_next   = cmd_reg;
        rtr_next   = rtr_reg;
        rcr_next   = rcr_reg;
        pip_next   = pip_reg;
        mac_next   = mac_reg;
        seq_next   = seq_reg;
        id_next    = id_reg;
        mask_next  = mask_reg;
        retry_next = retry_reg;
        txv_next   = 1'b0;
        arp_next   = arp_reg;
        ev_set     = 3'b000;
        rdata_next = rdata_reg;
        if (reg_rd)
            rdata_next = read_byte(reg_addr);

        if (reg_wr) begin
            unique case (reg_addr)
                sap_pkg::ADDR_CMD: begin
                    // Commands while busy are ignored
                    if (state_reg == sap_pkg::ST_IDLE && cmd_reg == 2'b00)
                        cmd_next = reg_wdata[1:0]; // RL1 RL2
                end
                sap_pkg::ADDR_RTR: rtr_next[15:8] = reg_wdata; // RL5
                sap_pkg::ADDR_RTR + 16'h0001:
                    rtr_next[7:0] = reg_wdata; // RL5
                sap_pkg::ADDR_RCR: rcr_next = reg_wdata;
                sap_pkg::ADDR_PIP: pip_next[31:24] = reg_wdata; // RL8
                sap_pkg::ADDR_PIP + 16'h0001:
                    pip_next[23:16] = reg_wdata; // RL8
                sap_pkg::ADDR_PIP + 16'h0002:
                    pip_next[15:8] = reg_wdata; // RL8
                sap_pkg::ADDR_PIP + 16'h0003:
                    pip_next[7:0] = reg_wdata; // RL8
                sap_pkg::ADDR_SEQ: seq_next[15:8] = reg_wdata; // RL10
                sap_pkg::ADDR_SEQ + 16'h0001:
                    seq_next[7:0] = reg_wdata; // RL10
                sap_pkg::ADDR_ID: id_next[15:8] = reg_wdata; // RL11
                sap_pkg::ADDR_ID + 16'h0001:
                    id_next[7:0] = reg_wdata; // RL11
                sap_pkg::ADDR_MASK: mask_next = reg_wdata[2:0];
                default: ;
            endcase
        end

        unique case (state_reg)
            sap_pkg::ST_IDLE: begin
                retry_next = 8'h00;
                if (cmd_reg != 2'b00) begin
                    // Both bits set is illegal; ARP is then taken
                    arp_next   = cmd_reg[sap_pkg::CMD_ARP_BIT];
                    state_next = sap_pkg::ST_SEND;
                end
            end
            sap_pkg::ST_SEND: begin
                txv_next   = 1'b1; // RL1 RL2 RL6
                state_next = sap_pkg::ST_WAIT;
            end
            sap_pkg::ST_WAIT: begin
                // A reply beats an expiry in the same cycle
                if (arp_reg && rx_arp_reply) begin
                    mac_next = rx_sender_mac; // RL9
                    ev_set[sap_pkg::EV_ARP_BIT] = 1'b1; // RL4
                end else if (!arp_reg && rx_echo_reply) begin
                    ev_set[sap_pkg::EV_PING_BIT] = 1'b1; // RL4
                end else if (tmr.expire) begin
                    if (retry_reg >= rcr_reg)
                        ev_set[sap_pkg::EV_TMO_BIT] = 1'b1; // RL7
                    else begin
                        retry_next = retry_reg + 8'h01; // RL6
                        state_next = sap_pkg::ST_SEND;
                    end
                end
                if (ev_set != 3'b000) begin
                    retry_next = 8'h00; // RL14
                    cmd_next   = 2'b00;
                    state_next = sap_pkg::ST_IDLE;
                end
            end
            // The fourth state code is unused; recover to idle
            default: state_next = sap_pkg::ST_IDLE;
        endcase

        flag_next = flag_reg;
        if (reg_wr && reg_addr == sap_pkg::ADDR_FLAGS)
            flag_next = flag_reg & ~reg_wdata[2:0]; // RL12
        flag_next = flag_next | ev_set; // RL12

        irq_n_next = !((flag_next & mask_next) != 3'b000
                       && int_pend_zero); // RL13
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= sap_pkg::ST_IDLE;
            cmd_reg   <= 2'b00;
            rtr_reg   <= sap_pkg::RTR_RESET;
            rcr_reg   <= sap_pkg::RCR_RESET;
            pip_reg   <= 32'h0000_0000;
            mac_reg   <= 48'h0000_0000_0000;
            seq_reg   <= 16'h0000;
            id_reg    <= 16'h0000;
            mask_reg  <= 3'h0;
            flag_reg  <= 3'h0;
            retry_reg <= 8'h00;
            rdata_reg <= 8'h00;
            txv_reg   <= 1'b0;
            arp_reg   <= 1'b0;
            irq_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cmd_reg   <= cmd_next;
            rtr_reg   <= rtr_next;
            rcr_reg   <= rcr_next;
            pip_reg   <= pip_next;
            mac_reg   <= mac_next;
            seq_reg   <= seq_next;
            id_reg    <= id_next;
            mask_reg  <= mask_next;
            flag_reg  <= flag_next;
            retry_reg <= retry_next;
            rdata_reg <= rdata_next;
            txv_reg   <= txv_next;
            arp_reg   <= arp_next;
            irq_n_reg <= irq_n_next;
        end
    end

    assign reg_rdata         = rdata_reg;
    assign tx_valid          = txv_reg;
    assign tx_is_arp         = arp_reg;
    assign tx_target_ip      = pip_reg;
    assign tx_echo_id        = id_reg;
    assign tx_echo_seq       = seq_reg;
    assign interrupt_out_low = irq_n_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic wait_reply;
    assign wait_reply = (arp_reg && rx_arp_reply) || (!arp_reg && rx_echo_reply);

    sequence s_resend;
        state_reg == sap_pkg::ST_SEND ##1 txv_reg;
    endsequence

    a_arp_cmd_sends: assert property ( // RL1
        $rose(cmd_reg[sap_pkg::CMD_ARP_BIT]) |-> ##2 (txv_reg && arp_reg))
        else $error("ARP command did not send an ARP request");
    a_ping_cmd_sends: assert property ( // RL2
        $rose(cmd_reg == 2'b01) |-> ##2 (txv_reg && !arp_reg))
        else $error("Echo command did not send an echo request");
    a_cmd_clear_event: assert property ( // RL4
        $fell(cmd_reg != 2'b00) |-> $past(ev_set != 3'b000))
        else $error("Command cleared without an event flag");
    a_interval_reset: assert property ( // RL5
        $fell(sys_rst) |-> rtr_reg == sap_pkg::RTR_RESET)
        else $error("Retry interval reset value wrong");
    a_expiry_resends: assert property ( // RL6
        (state_reg == sap_pkg::ST_WAIT && tmr.expire && !wait_reply
         && retry_reg < rcr_reg) |=> s_resend)
        else $error("Expiry did not resend request");
    a_limit_timeout: assert property ( // RL7
        (state_reg == sap_pkg::ST_WAIT && tmr.expire && !wait_reply
         && retry_reg >= rcr_reg) |=> flag_reg[sap_pkg::EV_TMO_BIT]
         && state_reg == sap_pkg::ST_IDLE)
        else $error("Retry limit did not raise timeout");
    a_ip_first_octet: assert property ( // RL8
        (reg_wr && reg_addr == sap_pkg::ADDR_PIP)
        |=> pip_reg[31:24] == $past(reg_wdata))
        else $error("Target IP first octet misplaced");
    a_mac_capture: assert property ( // RL9
        (state_reg == sap_pkg::ST_WAIT && arp_reg && rx_arp_reply)
        |=> mac_reg == $past(rx_sender_mac) && flag_reg[sap_pkg::EV_ARP_BIT])
        else $error("Peer MAC not captured");
    a_seq_host_only: assert property ( // RL10
        !(reg_wr && reg_addr >= sap_pkg::ADDR_SEQ
          && reg_addr < sap_pkg::ADDR_ID)
        |=> $stable(seq_reg))
        else $error("Sequence number changed without a write");
    a_id_high_byte: assert property ( // RL11
        (reg_wr && reg_addr == sap_pkg::ADDR_ID)
        |=> id_reg[15:8] == $past(reg_wdata))
        else $error("Identifier high byte misplaced");
    a_event_set_wins: assert property ( // RL12
        ev_set != 3'b000 |=> (flag_reg & $past(ev_set)) == $past(ev_set))
        else $error("Event lost against clear");
    a_irq_follows: assert property ( // RL13
        interrupt_out_low ==
        !((flag_reg & mask_reg) != 3'b000 && $past(int_pend_zero)))
        else $error("Interrupt output wrong");
    a_done_to_idle: assert property ( // RL14
        ev_set != 3'b000 |=> state_reg == sap_pkg::ST_IDLE
        && retry_reg == 8'h00 && cmd_reg == 2'b00 ##1 !txv_reg)
        else $error("Engine did not return to idle");
endmodule
`default_nettype wire

/* logic/sap_pkg.sv */
/*
 * Constants for the connectionless ARP / echo request engine: register
 * offsets, field positions, reset values and retransmission timing.
 * Assumes a 10 MHz system clock and a byte-wide host register port.
 */
// How it works
// RL1 - Writing one to command bit 1 sends an ARP request; bit self-clears.
// RL2 - Writing one to command bit 0 sends an echo request; bit self-clears.
// RL3 - Host never sets both bits, nor commands again before bits clear.
// RL4 - Outcome is reported only through the event flag register.
// RL5 - Retry interval is 16 bits in 100us units, reset 0x07D0, big-endian.
// RL6 - Without a reply, the request is resent each time the interval expires.
// RL7 - Retries beyond the retry limit raise the timeout flag.
// RL8 - Four-byte target IP register, first octet at lowest address.
// RL9 - An ARP reply stores the sender MAC, first octet at lowest address.
// RL10 - Echo sequence number is host-written only, never incremented.
// RL11 - Echo identifier register, 16-bit big-endian, resets to zero.
// RL12 - Event bits: 2 timeout, 1 ARP reply, 0 echo reply; write one clears.
// RL13 - Interrupt low while a flag is set, unmasked, and pending timer zero.
// RL14 - Reply or timeout stops retries, zeroes count, clears command.
`default_nettype none
package sap_pkg;
    localparam logic [15:0] ADDR_CMD      = 16'h004C;
    localparam logic [15:0] ADDR_RTR      = 16'h004D;
    localparam logic [15:0] ADDR_RCR      = 16'h004F;
    localparam logic [15:0] ADDR_PIP      = 16'h0050;
    localparam logic [15:0] ADDR_MAC      = 16'h0054;
    localparam logic [15:0] ADDR_SEQ      = 16'h005A;
    localparam logic [15:0] ADDR_ID       = 16'h005C;
    localparam logic [15:0] ADDR_MASK     = 16'h005E;
    localparam logic [15:0] ADDR_FLAGS    = 16'h005F;

    localparam int          CMD_PING_BIT  = 0;
    localparam int          CMD_ARP_BIT   = 1;
    localparam int          EV_PING_BIT   = 0;
    localparam int          EV_ARP_BIT    = 1;
    localparam int          EV_TMO_BIT    = 2;

    localparam logic [15:0] RTR_RESET     = 16'h07D0;
    localparam logic [7:0]  RCR_RESET     = 8'h00;

    localparam int          TICK_US       = 100;
    localparam int          CLK_MHZ       = 10;
    localparam int          TICK_CYCLES   = TICK_US * CLK_MHZ;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_WAIT
    } sap_state_e;
endpackage
`default_nettype wire

/* logic/sap_retry_timer.sv */
/*
 * Retransmission timer: counts 100us ticks up to the programmed interval
 * and pulses expire once. Assumes start is a one-cycle pulse.
 */
`timescale 1ns/100ps
`default_nettype none
module sap_retry_timer #(
    parameter int TICK_CYCLES = sap_pkg::TICK_CYCLES
) (
    input  wire logic  clk,
    input  wire logic  sys_rst,
    sap_timer_if.timer tmr
);
    logic [15:0] pre_reg;
    logic [15:0] pre_next;
    logic [15:0] unit_reg;
    logic [15:0] unit_next;
    logic        run_reg;
    logic        run_next;
    logic        exp_reg;
    logic        exp_next;

    localparam logic [15:0] PRE_LAST = 16'(TICK_CYCLES - 1);

    always_comb begin
        pre_next  = pre_reg;
        unit_next = unit_reg;
        run_next  = run_reg;
        exp_next  = 1'b0;
        if (tmr.start) begin
            pre_next  = 16'h0000;
            unit_next = 16'h0000;
            run_next  = 1'b1;
        end else if (tmr.stop) begin
            run_next = 1'b0;
        end else if (run_reg) begin
            if (pre_reg == PRE_LAST) begin
                pre_next  = 16'h0000;
                unit_next = unit_reg + 16'h0001;
                // A zero interval behaves as one unit rather than never
                if ({1'b0, unit_reg} + 17'h0_0001
                    >= {1'b0, tmr.interval}) begin
                    exp_next = 1'b1; // RL6
                    run_next = 1'b0;
                end
            end else begin
                pre_next = pre_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre_reg  <= 16'h0000;
            unit_reg <= 16'h0000;
            run_reg  <= 1'b0;
            exp_reg  <= 1'b0;
        end else begin
            pre_reg  <= pre_next;
            unit_reg <= unit_next;
            run_reg  <= run_next;
            exp_reg  <= exp_next;
        end
    end

    assign tmr.expire = exp_reg;
endmodule
`default_nettype wire

/* logic/sap_timer_if.sv */
/*
 * Link between the request engine and its retransmission timer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface sap_timer_if;
    logic        start;
    logic        stop;
    logic [15:0] interval;
    logic        expire;

    modport engine (output start, output stop, output interval, input expire);
    modport timer  (input start, input stop, input interval, output expire);
endinterface
`default_nettype wire

/* test/socketless_arp_ping_engine_tb.sv */
/*
 * Self-checking bench for the connectionless request engine: register
 * reset values and readback, ARP and echo commands, retries, timeout,
 * reply capture and the interrupt output.
 * Assumes sap_engine and sap_pkg are compiled first; TICK_CYCLES is
 * shortened to 4 so one interval unit lasts 4 clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module socketless_arp_ping_engine_tb;
    localparam int TICKS = 4;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        rx_arp_reply = 1'b0;
    logic [47:0] rx_sender_mac = '0;
    logic        rx_echo_reply = 1'b0;
    logic        int_pend_zero = 1'b1;
    logic        tx_valid;
    logic        tx_is_arp;
    logic [31:0] tx_target_ip;
    logic [15:0] tx_echo_id;
    logic [15:0] tx_echo_seq;
    logic        interrupt_out_low;
    int          fail_count = 0;
    int          num_checks = 0;
    int          tx_cnt = 0;
    int          base = 0;

    always #50 clk = ~clk;

    sap_engine #(.TICK_CYCLES(TICKS)) dut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .rx_arp_reply(rx_arp_reply),
        .rx_sender_mac(rx_sender_mac), .rx_echo_reply(rx_echo_reply),
        .int_pend_zero(int_pend_zero), .tx_valid(tx_valid),
        .tx_is_arp(tx_is_arp), .tx_target_ip(tx_target_ip),
        .tx_echo_id(tx_echo_id), .tx_echo_seq(tx_echo_seq),
        .interrupt_out_low(interrupt_out_low)
    );

    // Counts every request sent, so resends show up without polling
    always @(posedge clk) begin
        if (tx_valid === 1'b1) tx_cnt <= tx_cnt + 1;
    end

    task automatic wrap_up;
        if (fail_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    // Multi-byte registers go most significant byte first
    task automatic wrn(input logic [15:0] a, input int n,
                       input logic [47:0] v);
        for (int i = 0; i < n; i++) wr(a + 16'(i), v[8*(n-1-i) +: 8]);
    endtask

    task automatic rdchk(input logic [15:0] a, input int n,
                         input logic [47:0] exp);
        logic [47:0] v;
        logic [7:0]  b;
        v = '0;
        for (int i = 0; i < n; i++) begin
            rd(a + 16'(i), b);
            v = {v[39:0], b};
        end
        chk(v, exp);
    endtask

    task automatic wait_tx;
        bit seen;
        seen = 1'b0;
        for (int i = 0; i < 60 && !seen; i++) begin
            @(negedge clk);
            seen = (tx_valid === 1'b1);
        end
        if (!seen) begin
            fail_count++;
            wrap_up();
        end
    endtask

    task automatic wait_idle;
        logic [7:0] b;
        b = 8'hFF;
        for (int i = 0; i < 200 && b !== 8'h00; i++) rd(sap_pkg::ADDR_CMD, b);
        if (b !== 8'h00) begin
            fail_count++;
            wrap_up();
        end
    endtask

    // Sender address is scrambled once the pulse is over, never held
    task automatic pulse_rx(input logic arp, input logic [47:0] mac);
        @(negedge clk);
        rx_arp_reply = arp;
        rx_echo_reply = !arp;
        rx_sender_mac = mac;
        @(negedge clk);
        rx_arp_reply = 1'b0;
        rx_echo_reply = 1'b0;
        rx_sender_mac = ~mac;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        chk(interrupt_out_low, 1);
        rdchk(sap_pkg::ADDR_RTR, 2, sap_pkg::RTR_RESET);
        rdchk(sap_pkg::ADDR_RCR, 1, sap_pkg::RCR_RESET);
        rdchk(sap_pkg::ADDR_PIP, 4, '0);
        rdchk(sap_pkg::ADDR_MAC, 6, '0);
        rdchk(sap_pkg::ADDR_SEQ, 2, '0);
        rdchk(sap_pkg::ADDR_ID, 2, '0);
        rdchk(sap_pkg::ADDR_CMD, 1, '0);
        rdchk(sap_pkg::ADDR_FLAGS, 1, '0);
        rdchk(16'h0060, 1, '0);
        wrn(sap_pkg::ADDR_PIP, 4, 48'hC0A8_0015);
        rdchk(sap_pkg::ADDR_PIP, 4, 48'hC0A8_0015);
        wrn(sap_pkg::ADDR_SEQ, 2, 48'h03E8);
        rdchk(sap_pkg::ADDR_SEQ, 2, 48'h03E8);
        wrn(sap_pkg::ADDR_ID, 2, 48'h0100);
        rdchk(sap_pkg::ADDR_ID, 2, 48'h0100);
        wrn(sap_pkg::ADDR_MAC, 6, 48'h0102_0304_0506);
        rdchk(sap_pkg::ADDR_MAC, 6, '0);
        // ARP answered before the first expiry
        wrn(sap_pkg::ADDR_RTR, 2, 48'h0010);
        rdchk(sap_pkg::ADDR_RTR, 2, 48'h0010);
        wr(sap_pkg::ADDR_RCR, 8'h01);
        wr(sap_pkg::ADDR_MASK, 8'h07);
        base = tx_cnt;
        wr(sap_pkg::ADDR_CMD, 8'h02);
        wait_tx();
        chk(tx_is_arp, 1);
        chk(tx_target_ip, 48'hC0A8_0015);
        rdchk(sap_pkg::ADDR_CMD, 1, 48'h02);
        pulse_rx(1'b1, 48'h1122_33AA_BBCC);
        @(negedge clk);
        chk(interrupt_out_low, 0);
        rdchk(sap_pkg::ADDR_FLAGS, 1, 48'h02);
        rdchk(sap_pkg::ADDR_CMD, 1, '0);
        rdchk(sap_pkg::ADDR_MAC, 6, 48'h1122_33AA_BBCC);
        wr(sap_pkg::ADDR_FLAGS, 8'h02);
        @(negedge clk);
        chk(interrupt_out_low, 1);
        repeat (80) @(negedge clk);
        chk(48'(tx_cnt - base), 1);
        rdchk(sap_pkg::ADDR_FLAGS, 1, '0);
        // Echo with two resends, a wrong-kind reply, then timeout
        wrn(sap_pkg::ADDR_RTR, 2, 48'h0001);
        wr(sap_pkg::ADDR_RCR, 8'h02);
        wr(sap_pkg::ADDR_MASK, 8'h03);
        base = tx_cnt;
        wr(sap_pkg::ADDR_CMD, 8'h01);
        wait_tx();
        chk(tx_is_arp, 0);
        chk(tx_echo_id, 48'h0100);
        chk(tx_echo_seq, 48'h03E8);
        pulse_rx(1'b1, 48'h0A0B_0C0D_0E0F);
        wait_idle();
        chk(48'(tx_cnt - base), 3);
        rdchk(sap_pkg::ADDR_FLAGS, 1, 48'h04);
        rdchk(sap_pkg::ADDR_MAC, 6, 48'h1122_33AA_BBCC);
        rdchk(sap_pkg::ADDR_SEQ, 2, 48'h03E8);
        chk(interrupt_out_low, 1);
        wr(sap_pkg::ADDR_MASK, 8'h04);
        @(negedge clk);
        chk(interrupt_out_low, 0);
        int_pend_zero = 1'b0;
        repeat (2) @(negedge clk);
        chk(interrupt_out_low, 1);
        int_pend_zero = 1'b1;
        wr(sap_pkg::ADDR_FLAGS, 8'h04);
        rdchk(sap_pkg::ADDR_FLAGS, 1, '0);
        // Echo answered, no resend allowed
        wr(sap_pkg::ADDR_RCR, 8'h00);
        wrn(sap_pkg::ADDR_RTR, 2, 48'h0010);
        base = tx_cnt;
        wr(sap_pkg::ADDR_CMD, 8'h01);
        wait_tx();
        pulse_rx(1'b0, '0);
        rdchk(sap_pkg::ADDR_FLAGS, 1, 48'h01);
        rdchk(sap_pkg::ADDR_CMD, 1, '0);
        wr(sap_pkg::ADDR_FLAGS, 8'h01);
        // Limit zero: a single ARP attempt, then timeout
        wrn(sap_pkg::ADDR_RTR, 2, 48'h0001);
        base = tx_cnt;
        wr(sap_pkg::ADDR_CMD, 8'h02);
        wait_idle();
        chk(48'(tx_cnt - base), 1);
        rdchk(sap_pkg::ADDR_FLAGS, 1, 48'h04);
        wrap_up();
    end
endmodule
`default_nettype wire
